/* File: hw/vxg_gate.sv */
// legality gate for the virtualization-extension instructions
// ==========================================================================
// What this block does
// - guest entry, state load/save, interrupt-flag clear, monitor call and tagged invalidate need the enable bit.
// - secure startup and interrupt-flag set need the enable bit or the secure-startup capability, else fault.
// - guest mode is entered only by guest entry, and some instructions act differently inside it.
// - tlb entries carry an address-space tag so host and guest entries coexist without flushing.
// - guest entry faults invalid-opcode unless protected and enabled, else general-protection above privilege 0.
`include "vxg_consts.svh"

module vxg_gate
  import vxg_pkg::*;
#(
  parameter logic        CAP_VIRT     = 1'b1,
  parameter logic        CAP_SECSTART = 1'b1,
  parameter logic        CAP_LOCK     = 1'b1,
  parameter logic [31:0] UNLOCK_KEY   = 32'h5A5A_A5A5, // arbitrary value
  parameter int          TAG_W        = 8
) (
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // register port
  input  wire logic [`VXG_ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [31:0]           reg_rdata_o,
  // decode port
  input  wire logic                  instr_valid_i,
  input  wire vxg_op_t               instr_op_i,
  input  wire logic [1:0]            current_privilege_level_i,
  input  wire logic                  prot_mode_i,
  input  wire logic [TAG_W-1:0]      instr_tag_i,
  input  wire logic [31:0]           instr_addr_i,
  input  wire logic                  guest_exit_i,
  // decode answer
  output logic                       done_o,
  output logic                       exec_ok_o,
  output logic                       invalid_opcode_fault_o,
  output logic                       general_protection_fault_o,
  output logic                       guest_mode_o,
  output logic                       global_interrupt_flag_o,
  output logic                       exit_req_o,
  // tlb side and interrupt line
  output logic      [TAG_W-1:0]      tlb_tag_o,
  output logic                       tlb_inval_o,
  output logic      [TAG_W-1:0]      tlb_inval_tag_o,
  output logic      [31:0]           tlb_inval_addr_o,
  output logic                       irq_o
);

  localparam int NEV = `VXG_NUM_EVENTS;

  // ========================================================================
  // state
  typedef struct packed {
    logic             virt_ext_enable;
    logic             virt_disable;
    logic             virt_lock;
    logic [TAG_W-1:0] guest_tag;
    logic [NEV-1:0]   int_status;
    logic [NEV-1:0]   int_mask;
    vxg_world_t       world;
    logic             global_interrupt_flag;
    logic             done;
    logic             exec_ok;
    logic             ud;
    logic             gp;
    logic             exit_req;
    logic             irq;
    logic [31:0]      rdata;
  } vxg_state_t;

  vxg_state_t st_reg;
  vxg_state_t st_next;

  // ========================================================================
  // helpers
  // enable-only group: all of these touch guest state or the tlb
  function automatic logic needs_enable(input vxg_op_t op);
    case (op)
      VXG_OP_GUEST_ENTRY,
      VXG_OP_STATE_LOAD,
      VXG_OP_STATE_SAVE,
      VXG_OP_GIF_CLEAR,
      VXG_OP_MONITOR_CALL,
      VXG_OP_TAG_INVAL:    needs_enable = 1'b1;
      default:             needs_enable = 1'b0;
    endcase
  endfunction

  // startup group: also legal on the capability alone
  function automatic logic needs_either(input vxg_op_t op);
    case (op)
      VXG_OP_SECURE_START,
      VXG_OP_GIF_SET:      needs_either = 1'b1;
      default:             needs_either = 1'b0;
    endcase
  endfunction

  // plain register address match
  function automatic logic hit(input logic [`VXG_ADDR_W-1:0] a, input logic [`VXG_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // ========================================================================
  // decode-time legality, from live register values
  logic    dec;
  logic    ud_now;
  logic    gp_now;
  logic    ok_now;
  logic    in_guest;
  logic [NEV-1:0] ev;
  logic [31:0]    caps;
  logic [31:0]    state_word;

  // a write in the decode cycle is seen only by the next decode, so the
  // answer never depends on how bus and decode strobes line up
  always_comb begin
    dec      = instr_valid_i;
    in_guest = (st_reg.world == VXG_WORLD_GUEST);
    ud_now   = 1'b0;
    gp_now   = 1'b0;
    // enable-only group faults while the enable bit is clear
    if (needs_enable(instr_op_i) && !st_reg.virt_ext_enable) begin
      ud_now = 1'b1;
    end
    // secure-startup group also runs on the capability alone
    if (needs_either(instr_op_i) && !(st_reg.virt_ext_enable || CAP_SECSTART)) begin
      ud_now = 1'b1;
    end
    // guest entry: invalid-opcode checked first, then privilege
    if (instr_op_i == VXG_OP_GUEST_ENTRY) begin
      if (!prot_mode_i || !st_reg.virt_ext_enable) begin
        ud_now = 1'b1;
      end else if (current_privilege_level_i != `VXG_CPL_KERNEL) begin
        gp_now = 1'b1;
      end
    end
    ok_now = dec && !ud_now && !gp_now;
  end

  // ========================================================================
  // read views of capability and live state
  always_comb begin
    caps = 32'h0000_0000;
    caps[`VXG_BIT_CAP_VIRT]     = CAP_VIRT;
    caps[`VXG_BIT_CAP_SECSTART] = CAP_SECSTART;
    caps[`VXG_BIT_CAP_LOCK]     = CAP_LOCK;
    state_word = 32'h0000_0000;
    state_word[`VXG_BIT_ST_GUEST] = in_guest;
    state_word[`VXG_BIT_ST_GIF]   = st_reg.global_interrupt_flag;
    state_word[`VXG_ST_TAG_LSB +: TAG_W] = tlb_tag_o;
  end

  // ========================================================================
  // next state
  always_comb begin
    st_next          = st_reg;
    ev               = '0;
    st_next.done     = dec;
    st_next.exec_ok  = ok_now;
    st_next.ud       = dec && ud_now;
    st_next.gp       = dec && gp_now;
    st_next.exit_req = 1'b0;

    // world switches and interrupt flag
    if (ok_now) begin
      case (instr_op_i)
        VXG_OP_GUEST_ENTRY: begin
          if (!in_guest) begin
            st_next.world = VXG_WORLD_GUEST;
            st_next.global_interrupt_flag   = 1'b1;
            ev[`VXG_BIT_EV_ENTRY] = 1'b1;
          end
        end
        VXG_OP_MONITOR_CALL: begin
          // inside the guest the call leaves to the monitor
          if (in_guest) begin
            st_next.world    = VXG_WORLD_HOST;
            st_next.exit_req = 1'b1;
            ev[`VXG_BIT_EV_EXIT] = 1'b1;
          end
        end
        VXG_OP_GIF_CLEAR: st_next.global_interrupt_flag = 1'b0;
        VXG_OP_GIF_SET:   st_next.global_interrupt_flag = 1'b1;
        default:          st_next.global_interrupt_flag = st_reg.global_interrupt_flag;
      endcase
    end
    // exit from the intercept machinery
    if (guest_exit_i && in_guest) begin
      st_next.world = VXG_WORLD_HOST;
      ev[`VXG_BIT_EV_EXIT] = 1'b1;
    end
    ev[`VXG_BIT_EV_UD] = dec && ud_now;
    ev[`VXG_BIT_EV_GP] = dec && gp_now;

    // register writes
    // read-only views and unmapped offsets ignore writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        `VXG_OFS_FEATURE_EN: begin
          // enabling is refused without capability or while disabled
          if (!reg_wdata_i[`VXG_BIT_VIRT_EXT_EN] || (CAP_VIRT && !st_reg.virt_disable)) begin
            st_next.virt_ext_enable = reg_wdata_i[`VXG_BIT_VIRT_EXT_EN];
          end
        end
        `VXG_OFS_VIRT_CTRL: begin
          // once locked the disable bit is frozen until the key opens it
          if (!st_reg.virt_lock) begin
            st_next.virt_disable = reg_wdata_i[`VXG_BIT_DISABLE];
            st_next.virt_lock    = reg_wdata_i[`VXG_BIT_LOCK];
          end
        end
        `VXG_OFS_UNLOCK_KEY: begin
          if (CAP_LOCK && reg_wdata_i == UNLOCK_KEY) begin
            st_next.virt_lock = 1'b0;
          end
        end
        `VXG_OFS_INT_MASK:  st_next.int_mask  = reg_wdata_i[NEV-1:0];
        `VXG_OFS_GUEST_TAG: st_next.guest_tag = reg_wdata_i[TAG_W-1:0];
        default:            st_next.int_mask  = st_reg.int_mask;
      endcase
    end

    // mask writes never touch status, so a masked event keeps its trace
    // sticky status: write-one clears, a same-cycle event wins
    if (reg_wr_i && hit(reg_addr_i, `VXG_OFS_INT_STATUS)) begin
      st_next.int_status = st_reg.int_status & ~reg_wdata_i[NEV-1:0];
    end
    st_next.int_status = st_next.int_status | ev;
    st_next.irq        = |(st_next.int_status & st_next.int_mask);

    // zero outside the slot lets a shared bus or-combine read data
    // read data, valid only the cycle after the strobe
    st_next.rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `VXG_OFS_FEATURE_EN: st_next.rdata = {31'h0000_0000, st_reg.virt_ext_enable};
        `VXG_OFS_VIRT_CTRL:  st_next.rdata = {30'h0000_0000, st_reg.virt_lock, st_reg.virt_disable};
        `VXG_OFS_CAPS:       st_next.rdata = caps;
        `VXG_OFS_INT_STATUS: st_next.rdata = {{(32-NEV){1'b0}}, st_reg.int_status};
        `VXG_OFS_INT_MASK:   st_next.rdata = {{(32-NEV){1'b0}}, st_reg.int_mask};
        `VXG_OFS_STATE:      st_next.rdata = state_word;
        `VXG_OFS_GUEST_TAG:  st_next.rdata = {{(32-TAG_W){1'b0}}, st_reg.guest_tag};
        default:             st_next.rdata = 32'h0000_0000; // key reads as zero too
      endcase
    end
  end

  // ========================================================================
  // state register
  // sync reset; the interrupt flag is the only field
  // whose reset value is not zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg       <= '0;
      st_reg.world <= VXG_WORLD_HOST;
      st_reg.global_interrupt_flag   <= `VXG_RST_GIF;
    end else begin
      st_reg <= st_next;
    end
  end

  // ========================================================================
  // tlb tag unit sees the world that takes effect at the same edge
  // taking world and tag from the next state keeps tlb_tag_o aligned
  // with guest_mode_o; a registered copy would lag one cycle
  vxg_tag_unit #(
    .TAG_W (TAG_W)
  ) i_vxg_tag_unit (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .world_i      (st_next.world),
    .guest_tag_i  (st_next.guest_tag),
    .inval_i      (ok_now && instr_op_i == VXG_OP_TAG_INVAL),
    .inval_tag_i  (instr_tag_i),
    .inval_addr_i (instr_addr_i),
    .tag_o        (tlb_tag_o),
    .inval_o      (tlb_inval_o),
    .inval_tag_o  (tlb_inval_tag_o),
    .inval_addr_o (tlb_inval_addr_o)
  );

  // ========================================================================
  // outputs, all from flops
  // register read data
  assign reg_rdata_o                = st_reg.rdata;
  // decode answer pulses
  assign done_o                     = st_reg.done;
  assign exec_ok_o                  = st_reg.exec_ok;
  assign invalid_opcode_fault_o     = st_reg.ud;
  assign general_protection_fault_o = st_reg.gp;
  // world, interrupt flag, exit pulse and interrupt level
  assign guest_mode_o               = logic'(st_reg.world);
  assign global_interrupt_flag_o    = st_reg.global_interrupt_flag;
  assign exit_req_o                 = st_reg.exit_req;
  assign irq_o                      = st_reg.irq;

endmodule

/* File: hw/vxg_consts.svh */
// register offsets, field positions and reset values of the extension gate
`ifndef VXG_CONSTS_SVH
`define VXG_CONSTS_SVH

// ==========================================================================
// register offsets (byte addresses)
`define VXG_ADDR_W            8
`define VXG_OFS_FEATURE_EN    8'h00
`define VXG_OFS_VIRT_CTRL     8'h04
`define VXG_OFS_CAPS          8'h08
`define VXG_OFS_UNLOCK_KEY    8'h0C
`define VXG_OFS_INT_STATUS    8'h10
`define VXG_OFS_INT_MASK      8'h14
`define VXG_OFS_STATE         8'h18
`define VXG_OFS_GUEST_TAG     8'h1C

// ==========================================================================
// field positions
`define VXG_BIT_VIRT_EXT_EN   0
`define VXG_BIT_DISABLE       0
`define VXG_BIT_LOCK          1
`define VXG_BIT_CAP_VIRT      0
`define VXG_BIT_CAP_SECSTART  1
`define VXG_BIT_CAP_LOCK      2
`define VXG_BIT_EV_UD         0
`define VXG_BIT_EV_GP         1
`define VXG_BIT_EV_ENTRY      2
`define VXG_BIT_EV_EXIT       3
`define VXG_BIT_ST_GUEST      0
`define VXG_BIT_ST_GIF        1
`define VXG_ST_TAG_LSB        8
`define VXG_NUM_EVENTS        4

// ==========================================================================
// reset values and fixed codes
`define VXG_RST_GIF           1'b1
`define VXG_HOST_TAG          8'h00
`define VXG_CPL_KERNEL        2'h0

`endif

/* File: hw/vxg_pkg.sv */
// types shared by the extension gate and its tag unit
package vxg_pkg;

  // ========================================================================
  // instruction classes presented at decode
  typedef enum logic [3:0] {
    VXG_OP_GUEST_ENTRY  = 4'h0,
    VXG_OP_STATE_LOAD   = 4'h1,
    VXG_OP_STATE_SAVE   = 4'h2,
    VXG_OP_GIF_CLEAR    = 4'h3,
    VXG_OP_MONITOR_CALL = 4'h4,
    VXG_OP_TAG_INVAL    = 4'h5,
    VXG_OP_SECURE_START = 4'h6,
    VXG_OP_GIF_SET      = 4'h7,
    VXG_OP_OTHER        = 4'h8
  } vxg_op_t;

  // ========================================================================
  // world the core runs in
  typedef enum logic {
    VXG_WORLD_HOST  = 1'b0,
    VXG_WORLD_GUEST = 1'b1
  } vxg_world_t;

endpackage

/* File: hw/vxg_tag_unit.sv */
// address-space tag driver and tagged invalidate request for the tlb
`include "vxg_consts.svh"

module vxg_tag_unit
  import vxg_pkg::*;
#(
  parameter int TAG_W = 8
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire vxg_world_t       world_i,
  input  wire logic [TAG_W-1:0] guest_tag_i,
  input  wire logic             inval_i,
  input  wire logic [TAG_W-1:0] inval_tag_i,
  input  wire logic [31:0]      inval_addr_i,
  output logic      [TAG_W-1:0] tag_o,
  output logic                  inval_o,
  output logic      [TAG_W-1:0] inval_tag_o,
  output logic      [31:0]      inval_addr_o
);

  typedef struct packed {
    logic [TAG_W-1:0] tag;
    logic             inval;
    logic [TAG_W-1:0] inval_tag;
    logic [31:0]      inval_addr;
  } vxg_tag_state_t;

  vxg_tag_state_t st_reg;
  vxg_tag_state_t st_next;

  // ========================================================================
  // tag selection: entries keep their tag, so no flush on a world switch
  always_comb begin
    st_next            = st_reg;
    st_next.tag        = (world_i == VXG_WORLD_GUEST) ? guest_tag_i : `VXG_HOST_TAG;
    st_next.inval      = inval_i;
    st_next.inval_tag  = inval_i ? inval_tag_i : st_reg.inval_tag;
    st_next.inval_addr = inval_i ? inval_addr_i : st_reg.inval_addr;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tag_o        = st_reg.tag;
  assign inval_o      = st_reg.inval;
  assign inval_tag_o  = st_reg.inval_tag;
  assign inval_addr_o = st_reg.inval_addr;

endmodule

/* File: dv/vxg_gate_sva.sv */
// port-level checks on the extension gate
module vxg_gate_sva
  import vxg_pkg::*;
#(
  parameter logic CAP_SECSTART = 1'b1,
  parameter int   TAG_W        = 8
) (
  input wire logic             clk_i,
  input wire logic             reset_i,
  input wire logic             reg_rd_i,
  input wire logic [31:0]      reg_rdata_o,
  input wire logic             instr_valid_i,
  input wire vxg_op_t          instr_op_i,
  input wire logic [1:0]       current_privilege_level_i,
  input wire logic             prot_mode_i,
  input wire logic             done_o,
  input wire logic             exec_ok_o,
  input wire logic             invalid_opcode_fault_o,
  input wire logic             general_protection_fault_o,
  input wire logic             guest_mode_o,
  input wire logic [TAG_W-1:0] tlb_tag_o,
  input wire logic             tlb_inval_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // ==========================================================================
  // decode answers
  a_done_one_outcome: assert property (instr_valid_i |=> done_o && $onehot({exec_ok_o, invalid_opcode_fault_o,
    general_protection_fault_o})) else $error("decode answer missing or not single");
  a_done_has_cause: assert property (done_o |-> $past(instr_valid_i)) else $error("done without request");
  a_entry_unprot: assert property (instr_valid_i && instr_op_i == VXG_OP_GUEST_ENTRY && !prot_mode_i
    |=> invalid_opcode_fault_o) else $error("guest entry outside protected mode not refused");
  a_entry_priv: assert property (instr_valid_i && instr_op_i == VXG_OP_GUEST_ENTRY && !guest_mode_o
    && current_privilege_level_i != 2'h0 |=> !exec_ok_o && !guest_mode_o) else $error("guest entry above level 0");
  a_secstart_cap: assert property (instr_valid_i && CAP_SECSTART && (instr_op_i == VXG_OP_SECURE_START
    || instr_op_i == VXG_OP_GIF_SET) |=> exec_ok_o) else $error("capability-gated op refused");
  a_guest_only_entry: assert property ($rose(guest_mode_o) |-> exec_ok_o && $past(instr_valid_i)
    && $past(instr_op_i) == VXG_OP_GUEST_ENTRY) else $error("guest mode without guest entry");
  a_host_tag_zero: assert property (!guest_mode_o |-> tlb_tag_o == '0) else $error("host tag not zero");
  a_inval_cause: assert property (tlb_inval_o |-> exec_ok_o && $past(instr_valid_i)
    && $past(instr_op_i) == VXG_OP_TAG_INVAL) else $error("invalidate without its instruction");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("read data outside slot");

  // ==========================================================================
  // main scenarios reached
  c_guest_entry: cover property (instr_valid_i && instr_op_i == VXG_OP_GUEST_ENTRY ##1 guest_mode_o);
  c_gp_fault: cover property (general_protection_fault_o);
  c_inval: cover property (tlb_inval_o);
endmodule

/* File: dv/vxg_sw_model.sv */
// privileged software issuing extension instructions at decode
module vxg_sw_model
  import vxg_pkg::*;
(
  input  wire logic  clk_i,
  output logic       valid_o,
  output vxg_op_t    op_o,
  output logic [1:0] cpl_o,
  output logic       prot_o,
  output logic [7:0] tag_o,
  output logic [31:0] addr_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // idle values; tag and page stay fixed so the bench can predict them
  initial begin
    valid_o = 1'b0;
    op_o = VXG_OP_OTHER;
    cpl_o = 2'h0;
    prot_o = 1'b0;
    tag_o = 8'hA5;
    addr_o = 32'h0000_2000;
  end

  // one instruction per call, request held for exactly one sampling edge
  task automatic issue(input vxg_op_t op, input logic [1:0] current_privilege_level, input logic prot);
    @(posedge clk_i);
    valid_o <= 1'b1;
    op_o <= op;
    cpl_o <= current_privilege_level;
    prot_o <= prot;
    @(posedge clk_i);
    valid_o <= 1'b0;
  endtask

  // enable decision: 0 absent, 1 allowed, 2 locked by firmware, 3 needs key
  function automatic logic [1:0] verdict(input logic [31:0] caps, input logic [31:0] ctrl);
    if (!caps[0]) return 2'h0;
    if (!ctrl[0]) return 2'h1;
    return caps[2] ? 2'h3 : 2'h2;
  endfunction
endmodule

/* File: dv/tb_vxg_gate.sv */
// self-checking bench for the extension gate
`include "vxg_consts.svh"
module tb_vxg_gate
  import vxg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {vxg_op_t op; logic [1:0] current_privilege_level; logic prot; logic [3:0] res;} vxg_row_t;
  logic clk_i, reset_i, reg_wr_i, reg_rd_i, guest_exit_i, valid, prot, done_o, exec_ok_o, ud, gp;
  logic guest_mode_o, global_interrupt_flag, exit_req_o, tlb_inval_o, irq_o;
  logic [7:0] reg_addr_i, tag, tlb_tag_o, tlb_inval_tag_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, addr, tlb_inval_addr_o, caps_v, ctrl_v;
  logic [1:0] current_privilege_level;
  vxg_op_t op;
  int err_total = 0;
  int samples_checked = 0;
  // result nibble: ok, invalid-opcode, protection, guest mode after
  vxg_row_t rows[11] = '{'{VXG_OP_STATE_LOAD, 2'h0, 1'b1, 4'h8}, '{VXG_OP_STATE_SAVE, 2'h0, 1'b1, 4'h8},
    '{VXG_OP_GIF_CLEAR, 2'h0, 1'b1, 4'h8}, '{VXG_OP_TAG_INVAL, 2'h0, 1'b1, 4'h8},
    '{VXG_OP_GIF_SET, 2'h0, 1'b1, 4'h8}, '{VXG_OP_SECURE_START, 2'h0, 1'b1, 4'h8},
    '{VXG_OP_GUEST_ENTRY, 2'h3, 1'b1, 4'h2}, '{VXG_OP_GUEST_ENTRY, 2'h0, 1'b0, 4'h4},
    '{VXG_OP_GUEST_ENTRY, 2'h0, 1'b1, 4'h9}, '{VXG_OP_MONITOR_CALL, 2'h0, 1'b1, 4'h8},
    '{VXG_OP_OTHER, 2'h0, 1'b1, 4'h8}};

  vxg_gate i_vxg_gate (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .instr_valid_i(valid),
    .instr_op_i(op), .current_privilege_level_i(current_privilege_level), .prot_mode_i(prot), .instr_tag_i(tag),
    .instr_addr_i(addr), .guest_exit_i(guest_exit_i), .done_o(done_o), .exec_ok_o(exec_ok_o),
    .invalid_opcode_fault_o(ud), .general_protection_fault_o(gp), .guest_mode_o(guest_mode_o),
    .global_interrupt_flag_o(global_interrupt_flag), .exit_req_o(exit_req_o), .tlb_tag_o(tlb_tag_o), .tlb_inval_o(tlb_inval_o),
    .tlb_inval_tag_o(tlb_inval_tag_o), .tlb_inval_addr_o(tlb_inval_addr_o), .irq_o(irq_o));
  vxg_sw_model i_vxg_sw_model (.clk_i(clk_i), .valid_o(valid), .op_o(op), .cpl_o(current_privilege_level), .prot_o(prot),
    .tag_o(tag), .addr_o(addr));

  // ==========================================================================
  // clock, reset and a watchdog well past the expected 100 cycles
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // register cycles: strobes last one edge, read data checked in the slot after
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, output logic [31:0] v);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
    check(v, exp);
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    {reg_wr_i, reg_rd_i, guest_exit_i, reg_addr_i, reg_wdata_i} = '0;
    reset_i = 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    #1 check({global_interrupt_flag, guest_mode_o, tlb_tag_o}, {1'b1, 1'b0, 8'h00});
    rd(8'h20, 32'h0, caps_v);
    rd(`VXG_OFS_FEATURE_EN, 32'h0, caps_v);
    rd(`VXG_OFS_CAPS, 32'h7, caps_v);
    rd(`VXG_OFS_VIRT_CTRL, 32'h0, ctrl_v);
    check(i_vxg_sw_model.verdict(caps_v, ctrl_v), 2'h1);
    // disable bit set: enable write must be refused
    wr(`VXG_OFS_VIRT_CTRL, 32'h1);
    rd(`VXG_OFS_VIRT_CTRL, 32'h1, ctrl_v);
    check(i_vxg_sw_model.verdict(caps_v, ctrl_v), 2'h3);
    wr(`VXG_OFS_FEATURE_EN, 32'h1);
    rd(`VXG_OFS_FEATURE_EN, 32'h0, caps_v);
    wr(`VXG_OFS_VIRT_CTRL, 32'h0);
    // extension off: enable-only ops fault, capability-gated ops still run
    for (int k = 0; k < 9; k++) begin
      i_vxg_sw_model.issue(vxg_op_t'(k), 2'h0, 1'b1);
      #1 check({done_o, exec_ok_o, ud, gp}, (k < 6) ? 4'hA : 4'hC);
    end
    // sticky fault status drives the level interrupt only when unmasked
    check(irq_o, 1'b0);
    rd(`VXG_OFS_INT_STATUS, 32'h1, caps_v);
    wr(`VXG_OFS_INT_MASK, 32'h1);
    @(posedge clk_i);
    #1 check(irq_o, 1'b1);
    wr(`VXG_OFS_INT_STATUS, 32'hF);
    @(posedge clk_i);
    #1 check(irq_o, 1'b0);
    // extension on: table of ordinary cases
    wr(`VXG_OFS_GUEST_TAG, 32'h3C);
    wr(`VXG_OFS_FEATURE_EN, 32'h1);
    foreach (rows[i]) begin
      i_vxg_sw_model.issue(rows[i].op, rows[i].current_privilege_level, rows[i].prot);
      #1 check({done_o, exec_ok_o, ud, gp, guest_mode_o}, {1'b1, rows[i].res});
      check(tlb_tag_o, rows[i].res[0] ? 8'h3C : 8'h00);
      check(tlb_inval_o, rows[i].op == VXG_OP_TAG_INVAL);
      if (rows[i].op == VXG_OP_TAG_INVAL) check({tlb_inval_tag_o, tlb_inval_addr_o}, {8'hA5, 32'h2000});
      if (rows[i].op == VXG_OP_MONITOR_CALL) check(exit_req_o, 1'b1);
      if (rows[i].op inside {VXG_OP_GIF_CLEAR, VXG_OP_GIF_SET}) check(global_interrupt_flag, rows[i].op == VXG_OP_GIF_SET);
    end
    // a disabling write beside a decode affects only the next instruction
    fork
      wr(`VXG_OFS_FEATURE_EN, 32'h0);
      i_vxg_sw_model.issue(VXG_OP_STATE_LOAD, 2'h0, 1'b1);
    join
    #1 check({exec_ok_o, ud}, 2'h2);
    i_vxg_sw_model.issue(VXG_OP_STATE_LOAD, 2'h0, 1'b1);
    #1 check({exec_ok_o, ud}, 2'h1);
    // guest mode: state view, exit from outside, then a reset taken inside the guest
    wr(`VXG_OFS_INT_STATUS, 32'hF);
    wr(`VXG_OFS_FEATURE_EN, 32'h1);
    i_vxg_sw_model.issue(VXG_OP_GUEST_ENTRY, 2'h0, 1'b1);
    rd(`VXG_OFS_STATE, 32'h0000_3C03, caps_v);
    @(posedge clk_i);
    guest_exit_i <= 1'b1;
    @(posedge clk_i);
    guest_exit_i <= 1'b0;
    #1 check({guest_mode_o, tlb_tag_o}, {1'b0, 8'h00});
    rd(`VXG_OFS_INT_STATUS, 32'hC, caps_v);
    i_vxg_sw_model.issue(VXG_OP_GUEST_ENTRY, 2'h0, 1'b1);
    #1 check(guest_mode_o, 1'b1);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    #1 check({global_interrupt_flag, guest_mode_o, tlb_tag_o, irq_o}, {1'b1, 1'b0, 8'h00, 1'b0});
    rd(`VXG_OFS_STATE, 32'h2, caps_v);
    rd(`VXG_OFS_FEATURE_EN, 32'h0, caps_v);
    report_and_stop();
  end
endmodule

bind vxg_gate vxg_gate_sva #(.CAP_SECSTART(CAP_SECSTART), .TAG_W(TAG_W)) i_vxg_gate_sva (.clk_i(clk_i),
  .reset_i(reset_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .instr_valid_i(instr_valid_i),
  .instr_op_i(instr_op_i), .current_privilege_level_i(current_privilege_level_i), .prot_mode_i(prot_mode_i),
  .done_o(done_o), .exec_ok_o(exec_ok_o), .invalid_opcode_fault_o(invalid_opcode_fault_o),
  .general_protection_fault_o(general_protection_fault_o), .guest_mode_o(guest_mode_o),
  .tlb_tag_o(tlb_tag_o), .tlb_inval_o(tlb_inval_o));
